// File: i2c_register_access_slave.sv
// two-wire serial target giving a bus master access to a byte register space
// assumes scl and sda arrive asynchronously and are far slower than clk
`timescale 1ns/100ps
`include "i2c_slave_defs.svh"

// Operation
// R1: sda moves only while scl low
// R2: start is sda falling, scl high
// R3: master starts every transfer with start
// R4: stop ends transaction, back to idle
// R5: sample sda on rising scl
// R6: selection byte msb first, rw last
// R7: ignore transaction on address mismatch
// R8: acknowledge matching selection on ninth clock
// R9: first write byte loads address pointer
// R10: write selection then internal address byte
// R11: single data byte stored and acknowledged
// R12: burst writes acknowledged until stop; a full write buffer gets a missing acknowledge instead
// R13: read selection acked, pointer byte shifted
// R14: reads advance pointer after each byte
// R15: master acks wanted bytes, ends stop
// R16: random read via repeated start
// R17: burst read begins at pointer value
// R18: writes advance pointer after each byte
// R19: release sda on master ack clock
// R20: sda open-drain low only, scl never
module i2c_register_access_slave #(
  parameter logic [6:0] DEV_ADDR = `I2CS_DEV_ADDR,
  parameter int FIFO_DEPTH = `I2CS_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // serial link
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // register update stream
  output logic updValid,
  input wire logic updReady,
  output logic [7:0] updAddr,
  output logic [7:0] updData
);

  // ----------------------------------------
  // state and link events
  // ----------------------------------------
  i2c_slave_pkg::target_state_t q, d;
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  logic byteDone;
  logic selMatch;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [15:0] fifoOutData;
  logic [7:0] rdData;
  logic drain;

  // only the second and third sync stages feed the edge logic, never the first
  assign startCond = q.sclSync && q.sclPrev && q.sdaPrev && !q.sdaSync; // see R2
  assign stopCond = q.sclSync && q.sclPrev && !q.sdaPrev && q.sdaSync; // see R4
  assign sclRise = q.sclSync && !q.sclPrev;
  assign sclFall = !q.sclSync && q.sclPrev;
  assign byteDone = sclFall && (q.bitCnt == `I2CS_BYTE_BITS);
  assign selMatch = (q.shift[7:1] == DEV_ADDR);
  assign fifoOutReady = !q.updValid || updReady;
  assign drain = fifoOutValid && fifoOutReady;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.sclMeta = sclIn;
    d.sdaMeta = sdaIn;
    d.sclSync = q.sclMeta;
    d.sdaSync = q.sdaMeta;
    d.sclPrev = q.sclSync;
    d.sdaPrev = q.sdaSync;
    d.push = 1'b0;
    d.sdaOut = 1'b0; // see R20
    // drain into the register space and out to the core
    if (drain) begin
      d.updValid = 1'b1;
      d.updAddr = fifoOutData[15:8];
      d.updData = fifoOutData[7:0];
    end else if (updReady) begin
      d.updValid = 1'b0;
    end
    if (stopCond) begin
      d.phase = i2c_slave_pkg::IDLE; // see R4
      d.sdaOe = 1'b0;
    end else if (startCond) begin
      // a repeated start also lands here, see R16
      d.phase = i2c_slave_pkg::SEL_BYTE; // see R2
      d.bitCnt = `I2CS_BIT_RST;
      d.sdaOe = 1'b0;
    end else begin
      case (q.phase)
        i2c_slave_pkg::IDLE: begin
          d.sdaOe = 1'b0;
        end
        i2c_slave_pkg::SEL_BYTE: begin
          if (sclRise) begin
            d.shift = {q.shift[6:0], q.sdaSync}; // see R5, see R6
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (byteDone) begin
            if (selMatch) begin
              d.rw = q.shift[0];
              d.sdaOe = 1'b1; // see R8
              d.phase = i2c_slave_pkg::SEL_ACK;
            end else begin
              d.phase = i2c_slave_pkg::IGNORE; // see R7
            end
          end
        end
        i2c_slave_pkg::SEL_ACK: begin
          if (sclFall) begin
            d.bitCnt = `I2CS_BIT_RST;
            if (q.rw) begin
              // pointer byte goes out first, see R13, see R17
              d.tx = rdData;
              d.sdaOe = !rdData[7];
              d.ptr = q.ptr + 8'h01; // see R14
              d.phase = i2c_slave_pkg::RD_BYTE;
            end else begin
              d.sdaOe = 1'b0;
              d.phase = i2c_slave_pkg::REG_BYTE; // see R10
            end
          end
        end
        i2c_slave_pkg::REG_BYTE: begin
          if (sclRise) begin
            d.shift = {q.shift[6:0], q.sdaSync}; // see R5
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (byteDone) begin
            d.ptr = q.shift; // see R9
            d.sdaOe = 1'b1;
            d.phase = i2c_slave_pkg::REG_ACK;
          end
        end
        i2c_slave_pkg::REG_ACK: begin
          if (sclFall) begin
            d.sdaOe = 1'b0; // see R1
            d.bitCnt = `I2CS_BIT_RST;
            d.phase = i2c_slave_pkg::WR_BYTE;
          end
        end
        i2c_slave_pkg::WR_BYTE: begin
          if (sclRise) begin
            d.shift = {q.shift[6:0], q.sdaSync}; // see R5
            d.bitCnt = q.bitCnt + 4'h1;
          end else if (byteDone) begin
            // a full buffer refuses the byte with a missing acknowledge
            if (fifoInReady) begin
              d.push = 1'b1; // see R11
              d.pushWord = {q.ptr, q.shift};
              d.ptr = q.ptr + 8'h01; // see R18
              d.sdaOe = 1'b1; // see R12
              d.phase = i2c_slave_pkg::WR_ACK;
            end else begin
              d.phase = i2c_slave_pkg::IGNORE;
            end
          end
        end
        i2c_slave_pkg::WR_ACK: begin
          if (sclFall) begin
            d.sdaOe = 1'b0;
            d.bitCnt = `I2CS_BIT_RST;
            d.phase = i2c_slave_pkg::WR_BYTE; // see R12
          end
        end
        i2c_slave_pkg::RD_BYTE: begin
          if (sclFall) begin
            if (q.bitCnt == `I2CS_LAST_TX_BIT) begin
              d.sdaOe = 1'b0; // see R19
              d.phase = i2c_slave_pkg::RD_ACK;
            end else begin
              d.tx = {q.tx[6:0], 1'b0};
              d.sdaOe = !q.tx[6]; // see R1, see R20
              d.bitCnt = q.bitCnt + 4'h1;
            end
          end
        end
        i2c_slave_pkg::RD_ACK: begin
          if (sclRise) begin
            d.hostAck = !q.sdaSync; // see R15
          end else if (sclFall) begin
            if (q.hostAck) begin
              d.tx = rdData;
              d.sdaOe = !rdData[7];
              d.ptr = q.ptr + 8'h01; // see R14
              d.bitCnt = `I2CS_BIT_RST;
              d.phase = i2c_slave_pkg::RD_BYTE;
            end else begin
              d.sdaOe = 1'b0;
              d.phase = i2c_slave_pkg::IGNORE; // see R19
            end
          end
        end
        i2c_slave_pkg::IGNORE: begin
          d.sdaOe = 1'b0; // see R7
        end
        default: begin
          d.sdaOe = 1'b0;
          d.phase = i2c_slave_pkg::IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.sclMeta <= 1'b1;
      q.sdaMeta <= 1'b1;
      q.sclSync <= 1'b1;
      q.sdaSync <= 1'b1;
      q.sclPrev <= 1'b1;
      q.sdaPrev <= 1'b1;
      q.phase <= i2c_slave_pkg::IDLE;
      q.ptr <= `I2CS_PTR_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sdaOut = q.sdaOut;
  assign sdaOe = q.sdaOe;
  assign updValid = q.updValid;
  assign updAddr = q.updAddr;
  assign updData = q.updData;

  // ----------------------------------------
  // write buffer and register space
  // ----------------------------------------
  // reads do not wait for queued writes; a read right after a burst
  // may see old data while updReady holds the buffer back
  sync_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .rst(rst),
    .inValid(q.push),
    .inReady(fifoInReady),
    .inData(q.pushWord),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  reg_space_mem #(
    .AW(8),
    .DW(8)
  ) u_regs (
    .clk(clk),
    .rst(rst),
    .wrEn(drain),
    .wrAddr(fifoOutData[15:8]),
    .wrData(fifoOutData[7:0]),
    .rdAddr(q.ptr),
    .rdData(rdData)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_sda_moves_low;
    @(posedge clk) disable iff (rst)
    (q.sdaOe != $past(q.sdaOe)) |-> $past(sclFall || startCond || stopCond || !q.sclSync);
  endproperty
  a_sda_moves_low: assert property (p_sda_moves_low) // see R1
    else $error("sda enable changed while scl high");

  property p_start_seen;
    @(posedge clk) disable iff (rst)
    (startCond && !stopCond) |=> (q.phase == i2c_slave_pkg::SEL_BYTE) && (q.bitCnt == 4'h0);
  endproperty
  a_start_seen: assert property (p_start_seen) // see R2
    else $error("start not taken");

  property p_stop_idle;
    @(posedge clk) disable iff (rst)
    stopCond |=> (q.phase == i2c_slave_pkg::IDLE) && !q.sdaOe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) // see R4
    else $error("stop did not return to idle");

  property p_sample_rise;
    @(posedge clk) disable iff (rst)
    (sclRise && !startCond && !stopCond && (q.phase == i2c_slave_pkg::SEL_BYTE))
      |=> (q.shift[0] == $past(q.sdaSync)) && (q.bitCnt == $past(q.bitCnt) + 4'h1);
  endproperty
  a_sample_rise: assert property (p_sample_rise) // see R5
    else $error("bit not sampled on rising scl");

  property p_mismatch_quiet;
    @(posedge clk) disable iff (rst)
    (q.phase == i2c_slave_pkg::SEL_BYTE && byteDone && !selMatch && !startCond && !stopCond)
      |=> (q.phase == i2c_slave_pkg::IGNORE) ##0 !q.sdaOe [*4];
  endproperty
  a_mismatch_quiet: assert property (p_mismatch_quiet) // see R7
    else $error("answered a foreign address");

  property p_sel_ack;
    @(posedge clk) disable iff (rst)
    (q.phase == i2c_slave_pkg::SEL_BYTE && byteDone && selMatch && !startCond && !stopCond)
      |=> q.sdaOe && (q.phase == i2c_slave_pkg::SEL_ACK) && (q.rw == $past(q.shift[0]));
  endproperty
  a_sel_ack: assert property (p_sel_ack) // see R8
    else $error("matching selection not acknowledged");

  property p_ptr_load;
    @(posedge clk) disable iff (rst)
    (q.phase == i2c_slave_pkg::REG_BYTE && byteDone && !startCond && !stopCond)
      |=> (q.ptr == $past(q.shift)) && q.sdaOe;
  endproperty
  a_ptr_load: assert property (p_ptr_load) // see R9
    else $error("address byte not loaded");

  property p_write_store;
    @(posedge clk) disable iff (rst)
    (q.phase == i2c_slave_pkg::WR_BYTE && byteDone && fifoInReady && !startCond && !stopCond)
      |=> q.push && (q.pushWord == {$past(q.ptr), $past(q.shift)})
          && (q.ptr == $past(q.ptr) + 8'h01);
  endproperty
  a_write_store: assert property (p_write_store) // see R18
    else $error("data byte not queued or pointer not advanced");

  property p_read_first;
    @(posedge clk) disable iff (rst)
    (q.phase == i2c_slave_pkg::SEL_ACK && sclFall && q.rw && !startCond && !stopCond)
      |=> (q.phase == i2c_slave_pkg::RD_BYTE) && (q.sdaOe == !$past(rdData[7]))
          && (q.ptr == $past(q.ptr) + 8'h01);
  endproperty
  a_read_first: assert property (p_read_first) // see R13
    else $error("read byte not started from pointer");

  property p_nack_release;
    @(posedge clk) disable iff (rst)
    (q.phase == i2c_slave_pkg::RD_ACK && sclFall && !q.hostAck && !startCond && !stopCond)
      |=> (q.phase == i2c_slave_pkg::IGNORE) && !q.sdaOe;
  endproperty
  a_nack_release: assert property (p_nack_release) // see R19
    else $error("kept driving after missing acknowledge");

  property p_drive_low_only;
    @(posedge clk) disable iff (rst)
    q.sdaOe |-> !q.sdaOut && !(q.phase inside {i2c_slave_pkg::IDLE, i2c_slave_pkg::IGNORE});
  endproperty
  a_drive_low_only: assert property (p_drive_low_only) // see R20
    else $error("sda driven high");

  c_write_ack: cover property (@(posedge clk) disable iff (rst)
    q.phase == i2c_slave_pkg::WR_ACK);
  c_read_cont: cover property (@(posedge clk) disable iff (rst)
    q.phase == i2c_slave_pkg::RD_ACK && sclFall && q.hostAck);
  c_foreign: cover property (@(posedge clk) disable iff (rst)
    q.phase == i2c_slave_pkg::IGNORE);
  c_rep_start: cover property (@(posedge clk) disable iff (rst)
    startCond && q.phase == i2c_slave_pkg::WR_BYTE);

endmodule

// File: i2c_slave_defs.svh
// constants of the two-wire register access target
// assumes inclusion by bare name from the design files
`ifndef I2C_SLAVE_DEFS_SVH
`define I2C_SLAVE_DEFS_SVH

// ----------------------------------------
// addressing
// ----------------------------------------
`define I2CS_DEV_ADDR 7'h30
`define I2CS_PTR_RST 8'h00

// ----------------------------------------
// sizes and counts
// ----------------------------------------
`define I2CS_FIFO_DEPTH 32
`define I2CS_BYTE_BITS 4'h8
`define I2CS_LAST_TX_BIT 4'h7
`define I2CS_BIT_RST 4'h0

`endif

// File: i2c_slave_pkg.sv
// types of the two-wire register access target
// assumes nothing beyond a SystemVerilog compiler
package i2c_slave_pkg;

  // ----------------------------------------
  // protocol phases
  // ----------------------------------------
  typedef enum logic [3:0] {
    IDLE,
    SEL_BYTE,
    SEL_ACK,
    REG_BYTE,
    REG_ACK,
    WR_BYTE,
    WR_ACK,
    RD_BYTE,
    RD_ACK,
    IGNORE
  } phase_t;

  // ----------------------------------------
  // whole state of the target
  // ----------------------------------------
  typedef struct packed {
    logic sclMeta;
    logic sdaMeta;
    logic sclSync;
    logic sdaSync;
    logic sclPrev;
    logic sdaPrev;
    phase_t phase;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic [7:0] ptr;
    logic rw;
    logic hostAck;
    logic sdaOe;
    logic sdaOut;
    logic push;
    logic [15:0] pushWord;
    logic updValid;
    logic [7:0] updAddr;
    logic [7:0] updData;
  } target_state_t;

endpackage

// File: sync_fifo.sv
// first-in first-out buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/100ps
module sync_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } fifo_state_t;

  fifo_state_t q, d;
  logic [WIDTH-1:0] store [DEPTH];
  logic full;
  logic empty;

  // ----------------------------------------
  // flags from the extra pointer bit
  // ----------------------------------------
  assign full = (q.wrPtr[AW] != q.rdPtr[AW]) && (q.wrPtr[AW-1:0] == q.rdPtr[AW-1:0]);
  assign empty = (q.wrPtr == q.rdPtr);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = store[q.rdPtr[AW-1:0]];

  always_comb begin
    d = q;
    if (inValid && !full) begin
      d.wrPtr = q.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      d.rdPtr = q.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage needs no reset, flags guard it
  always_ff @(posedge clk) begin
    if (inValid && !full) begin
      store[q.wrPtr[AW-1:0]] <= inData;
    end
  end

endmodule

// File: reg_space_mem.sv
// byte-wide register space, one write and one registered read port
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/100ps
module reg_space_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  // read port
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);

  logic [DW-1:0] cells [2**AW];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  // read data leave from a register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= '0;
    end else begin
      rdData <= cells[rdAddr];
    end
  end

endmodule

// File: i2c_master_model.sv
// behavioural two-wire bus master driving the target's link
// assumes a pull-up on sda, so a released line reads high
`timescale 1ns/100ps
module i2c_master_model #(
  parameter int QTR = 40
) (
  // link
  output logic scl,
  output logic sdaRel,
  input wire logic sda
);
  // ------
  // idle bus
  // ------
  // scl stands high between frames, no free-running clock
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  // ------
  // bus conditions
  // ------
  // works from idle and as a repeated start with scl low
  // non-blocking so a change on a clk edge lands after the sync flops sample
  task automatic start();
    sdaRel <= 1'b1;
    #QTR scl <= 1'b1;
    #QTR sdaRel <= 1'b0;
    #QTR scl <= 1'b0;
    #QTR;
  endtask

  task automatic stop();
    sdaRel <= 1'b0;
    #QTR scl <= 1'b1;
    #QTR sdaRel <= 1'b1;
    #QTR;
  endtask

  // ------
  // bits and bytes
  // ------
  // sda only moves with scl low, held across the rising edge
  task automatic bitOut(input logic b);
    sdaRel <= b;
    #QTR scl <= 1'b1;
    #(2 * QTR) scl <= 1'b0;
    #QTR;
  endtask

  task automatic bitIn(output logic b);
    sdaRel <= 1'b1;
    #QTR scl <= 1'b1;
    #QTR b = sda;
    #QTR scl <= 1'b0;
    #QTR;
  endtask

  task automatic writeByte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bitOut(d[i]);
    end
    bitIn(b);
    ack = !b;
  endtask

  // master acks each byte it wants followed by another
  task automatic readByte(input logic more, output logic [7:0] d);
    logic b;
    d = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bitIn(b);
      d = {d[6:0], b};
    end
    bitOut(!more);
  endtask
endmodule

// File: tb_i2c_register_access_slave.sv
// self-checking bench for the two-wire register access target
// assumes the master model file and the design files compiled before it
`timescale 1ns/100ps
`include "i2c_slave_defs.svh"
module tb_i2c_register_access_slave;
  localparam int DEPTH = 32;
  localparam logic [6:0] DEV = `I2CS_DEV_ADDR;
  // ------
  // signals
  // ------
  logic clk;
  logic rst;
  logic scl;
  logic sdaRel;
  wire logic sdaWire;
  logic sdaOut;
  logic sdaOe;
  logic updValid;
  logic updReady;
  logic [7:0] updAddr;
  logic [7:0] updData;
  logic holdLow;
  logic [31:0] rndState;
  logic [7:0] mem [256];
  logic [15:0] expQ [$];
  int nErrors;
  int nCompared;

  // pull-up: low only while someone pulls
  assign sdaWire = sdaRel & (sdaOe ? sdaOut : 1'b1);

  i2c_register_access_slave #(.DEV_ADDR(DEV), .FIFO_DEPTH(DEPTH)) i_dut (
    .clk(clk), .rst(rst), .sclIn(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .updValid(updValid), .updReady(updReady), .updAddr(updAddr), .updData(updData)
  );
  i2c_master_model i_master (.scl(scl), .sdaRel(sdaRel), .sda(sdaWire));

  // ------
  // helpers
  // ------
  function automatic logic [31:0] rnd();
    rndState = rndState ^ (rndState << 13);
    rndState = rndState ^ (rndState >> 17);
    rndState = rndState ^ (rndState << 5);
    return rndState;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic closeOut();
    if (nErrors == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic sendByte(input logic [7:0] b, input logic expAck);
    logic ack;
    i_master.writeByte(b, ack);
    check({31'h0, ack}, {31'h0, expAck});
  endtask

  task automatic wrBurst(input logic [7:0] a, input int n);
    logic [7:0] d;
    i_master.start();
    sendByte({DEV, 1'b0}, 1'b1);
    sendByte(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'(rnd());
      mem[a] = d;
      expQ.push_back({a, d});
      sendByte(d, 1'b1);
      a++;
    end
    i_master.stop();
  endtask

  task automatic setPtr(input logic [7:0] a, input logic doStop);
    i_master.start();
    sendByte({DEV, 1'b0}, 1'b1);
    sendByte(a, 1'b1);
    if (doStop) begin
      i_master.stop();
    end
  endtask

  task automatic rdBytes(input logic [7:0] a, input int n);
    logic [7:0] d;
    i_master.start();
    sendByte({DEV, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      i_master.readByte(i < n - 1, d);
      check({24'h0, d}, {24'h0, mem[a]});
      a++;
    end
    #100;
    check({31'h0, sdaOe}, 32'h0);
    i_master.stop();
  endtask

  // reads do not wait for queued writes, so empty the buffer first
  task automatic drain();
    for (int i = 0; i < 4000 && expQ.size() != 0; i++) begin
      @(posedge clk);
    end
    check(32'(expQ.size()), 32'h0);
    repeat (4) @(posedge clk);
  endtask

  // ------
  // clock, stall pattern, watchers
  // ------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    updReady <= holdLow ? 1'b0 : ((rnd() & 32'h3) != 32'h0);
  end

  always @(posedge clk) begin
    if (rst === 1'b0 && updValid === 1'b1 && updReady === 1'b1) begin
      if (expQ.size() == 0) begin
        check({16'h0, updAddr, updData}, 32'hffffffff);
      end else begin
        check({16'h0, updAddr, updData}, {16'h0, expQ.pop_front()});
      end
    end
  end

  always @(sdaOe) begin
    if (rst === 1'b0) begin
      check({31'h0, scl}, 32'h0);
      check({31'h0, sdaOut}, 32'h0);
    end
  end

  initial begin
    #400000;
    nErrors++;
    closeOut();
  end

  // ------
  // main sequence
  // ------
  initial begin
    logic [7:0] a1;
    logic [7:0] a;
    logic [7:0] d;
    logic ack;
    int nAck;
    rndState = 32'ha58139e5;
    nErrors = 0;
    nCompared = 0;
    holdLow = 1'b0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // single write, pointer kept across stop
    a1 = 8'(rnd());
    wrBurst(a1, 1);
    drain();
    setPtr(a1, 1'b1);
    rdBytes(a1, 1);
    // burst across the pointer wrap, then random and current reads
    wrBurst(8'hfd, 5);
    drain();
    setPtr(8'hfd, 1'b0);
    rdBytes(8'hfd, 4);
    rdBytes(8'h01, 1);
    // near-miss addresses in both directions are ignored
    for (int k = 0; k < 6; k++) begin
      i_master.start();
      sendByte({DEV ^ (7'h01 << ((k % 3) * 3)), 1'(k)}, 1'b0);
      sendByte(8'(rnd()), 1'b0);
      i_master.stop();
    end
    // full buffer refuses with a nack, no stretching
    holdLow <= 1'b1;
    nAck = 0;
    a = 8'h40;
    setPtr(a, 1'b0);
    for (int i = 0; i < 40; i++) begin
      d = 8'(rnd());
      i_master.writeByte(d, ack);
      if (!ack) begin
        break;
      end
      mem[a] = d;
      expQ.push_back({a, d});
      a++;
      nAck++;
    end
    check(32'(nAck >= DEPTH && nAck <= DEPTH + 2), 32'h1);
    i_master.stop();
    holdLow <= 1'b0;
    drain();
    setPtr(8'h40, 1'b0);
    rdBytes(8'h40, 3);
    closeOut();
  end
endmodule
